// File: verilog/uart_iir_defs.svh
// constants for the fifo control and interrupt identification block
`ifndef UART_IIR_DEFS_SVH
`define UART_IIR_DEFS_SVH
// ==========================================================
// addresses
`define IIR_FCR_ADDR     32'h5000_1008
`define IRQ_STATUS_ADDR  32'h5000_1100
`define IRQ_MASK_ADDR    32'h5000_1104
`define FLOW_CTRL_ADDR   32'h5000_1108
// ==========================================================
// field positions
`define RT_HI            7
`define RT_LO            6
`define TET_HI           5
`define TET_LO           4
`define DMA_SIGNALLING_MODE_BIT         3
`define XCLR_BIT         2
`define RCLR_BIT         1
`define FIFOE_BIT        0
`define AFC_BIT          0
// ==========================================================
// reset values
`define RT_RESET         2'h0
`define TET_RESET        2'h0
`define DMA_SIGNALLING_MODE_RESET       1'h0
`define FIFOE_RESET      1'h0
`define AFC_RESET        1'h0
`define IRQ_RESET        3'h0
// ==========================================================
// fifo depth and levels
`define FIFO_DEPTH       5'h10
`define RX_LVL_ONE       5'h01
`define RX_LVL_QUARTER   5'h04
`define RX_LVL_HALF      5'h08
`define RX_LVL_TWO_LESS  5'h0E
`define TX_LVL_EMPTY     5'h00
`define TX_LVL_TWO       5'h02
`define TX_LVL_QUARTER   5'h04
`define TX_LVL_HALF      5'h08
// ==========================================================
// identification codes
`define ID_NONE          4'h1
`define ID_HOLDING_EMPTY_INTERRUPT          4'h2
`define ID_RX_DATA       4'h4
`define ID_LINE          4'h6
`define ID_BUSY          4'h7
`define ID_TIMEOUT       4'hC
`define ID_MODEM         4'h0
`define FIFOS_ENABLED_INDICATION_ON        2'h3
`define FIFOS_ENABLED_INDICATION_OFF       2'h0
`endif

// File: verilog/uart_iir_pkg.sv
// types shared by the fifo control and identification block
package uart_iir_pkg;
  `include "uart_iir_defs.svh"
  // ==========================================================
  // pending interrupt codes
  typedef enum logic [3:0] {
    ID_MODEM_E   = `ID_MODEM,
    ID_NONE_E    = `ID_NONE,
    ID_HOLDING_EMPTY_INTERRUPT_E    = `ID_HOLDING_EMPTY_INTERRUPT,
    ID_RX_DATA_E = `ID_RX_DATA,
    ID_LINE_E    = `ID_LINE,
    ID_BUSY_E    = `ID_BUSY,
    ID_TIMEOUT_E = `ID_TIMEOUT
  } pending_interrupt_code_e;
  typedef logic [4:0] fifo_count_t;
endpackage : uart_iir_pkg

// File: verilog/level_if.sv
// fifo count and level code carried to a threshold comparator
`timescale 1ns/1ps
interface level_if;
  logic [4:0] count;
  logic [1:0] code;
  logic       hit;
  modport src (output count, output code, input hit);
  modport cmp (input count, input code, output hit);
endinterface : level_if

// File: verilog/level_cmp.sv
// fifo level comparator for receive trigger or transmit empty threshold
`timescale 1ns/1ps
`include "uart_iir_defs.svh"
module level_cmp
  import uart_iir_pkg::*;
#(
  parameter bit IS_TX = 1'b0
) (
  level_if.cmp lv
);
  logic [4:0] thr;

  // ==========================================================
  // code to level
  always_comb begin
    thr = `RX_LVL_ONE;
    case (lv.code)
      2'h0: thr = IS_TX ? `TX_LVL_EMPTY   : `RX_LVL_ONE;
      2'h1: thr = IS_TX ? `TX_LVL_TWO     : `RX_LVL_QUARTER;
      2'h2: thr = IS_TX ? `TX_LVL_QUARTER : `RX_LVL_HALF;
      2'h3: thr = IS_TX ? `TX_LVL_HALF    : `RX_LVL_TWO_LESS;
      default: thr = `RX_LVL_ONE;
    endcase
  end

  // receive hits at or above, transmit at or below
  assign lv.hit = IS_TX ? (lv.count <= thr) : (lv.count >= thr);
endmodule : level_cmp

// File: verilog/uart_fifo_ctrl_int_ident.sv
// fifo control and interrupt identification register with apb access
`timescale 1ns/1ps
`include "uart_iir_defs.svh"
module uart_fifo_ctrl_int_ident
  import uart_iir_pkg::*;
(
  // clock and reset
  input  wire logic        mclk,
  input  wire logic        rst_n,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  // fifo fill levels
  input  wire logic [4:0]  rx_fifo_count,
  input  wire logic [4:0]  tx_fifo_count,
  // interrupt causes gated by their enables; rx data comes in as its enable only
  input  wire logic        line_status_irq,
  input  wire logic        rx_data_irq_en,
  input  wire logic        char_timeout_irq,
  input  wire logic        holding_empty_interrupt,
  input  wire logic        modem_status_irq,
  input  wire logic        busy_detect_irq,
  // fifo and flow outputs
  output logic             fifos_enabled_indication,
  output logic             transmit_fifo_clear,
  output logic             receive_fifo_clear,
  output logic             rts_n,
  output logic             dma_rx_req_n,
  output logic             dma_tx_req_n,
  output logic             irq
);
  // ==========================================================
  // registers and wires
  logic [1:0]              receive_trigger_level;
  logic [1:0]              transmit_empty_threshold;
  logic                    dma_signalling_mode;
  logic                    auto_flow_en;
  logic [2:0]              irq_status;
  logic [2:0]              irq_mask;
  logic                    rx_req_hold;
  logic                    tx_req_hold;
  logic                    rx_hit_d;
  logic                    tx_hit_d;
  logic                    pend_d;
  logic                    wr_en;
  logic                    sel_fcr;
  logic                    sel_sts;
  logic                    sel_msk;
  logic                    sel_afc;
  logic                    mapped;
  logic                    fifoe_wr;
  logic [2:0]              next_irq_status;
  logic [2:0]              irq_event;
  logic [2:0]              next_irq_mask;
  logic [31:0]             next_prdata;
  pending_interrupt_code_e pending_interrupt_code;
  logic [7:0]              fifo_state_rx_level_field;

  level_if rx_lv ();
  level_if tx_lv ();

  // ==========================================================
  // level comparators
  // one comparator per direction, each mapping the code through its own level table
  assign rx_lv.count = rx_fifo_count;
  assign rx_lv.code  = receive_trigger_level;
  assign tx_lv.count = tx_fifo_count;
  assign tx_lv.code  = transmit_empty_threshold;

  level_cmp #(.IS_TX(1'b0)) u_rx_cmp (.lv(rx_lv));
  level_cmp #(.IS_TX(1'b1)) u_tx_cmp (.lv(tx_lv));

  // ==========================================================
  // apb decode, zero wait states
  // full word compare, so aliases of a register are refused
  // pready stays high: every answer is ready in the access cycle
  assign sel_fcr = (paddr == `IIR_FCR_ADDR);
  assign sel_sts = (paddr == `IRQ_STATUS_ADDR);
  assign sel_msk = (paddr == `IRQ_MASK_ADDR);
  assign sel_afc = (paddr == `FLOW_CTRL_ADDR);
  assign mapped  = sel_fcr | sel_sts | sel_msk | sel_afc;
  assign pready  = 1'b1;
  assign pslverr = psel & penable & ~mapped;
  assign wr_en   = psel & penable & pwrite;
  assign fifoe_wr = wr_en & sel_fcr;

  // ==========================================================
  // fifo control fields
  // fields land on the access edge of a write
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      receive_trigger_level    <= `RT_RESET;
      transmit_empty_threshold <= `TET_RESET;
      dma_signalling_mode      <= `DMA_SIGNALLING_MODE_RESET;
      fifos_enabled_indication <= `FIFOE_RESET;
    end else if (fifoe_wr) begin
      receive_trigger_level    <= pwdata[`RT_HI:`RT_LO];
      transmit_empty_threshold <= pwdata[`TET_HI:`TET_LO];
      dma_signalling_mode      <= pwdata[`DMA_SIGNALLING_MODE_BIT];
      fifos_enabled_indication <= pwdata[`FIFOE_BIT];
    end
  end

  // clear pulses last one cycle, so software never writes zero back
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      transmit_fifo_clear <= 1'b0;
      receive_fifo_clear  <= 1'b0;
    end else begin
      // toggling the enable also empties both fifos
      transmit_fifo_clear <= fifoe_wr & (pwdata[`XCLR_BIT] |
        (pwdata[`FIFOE_BIT] != fifos_enabled_indication));
      receive_fifo_clear  <= fifoe_wr & (pwdata[`RCLR_BIT] |
        (pwdata[`FIFOE_BIT] != fifos_enabled_indication));
    end
  end

  // ==========================================================
  // flow control enable
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      auto_flow_en <= `AFC_RESET;
    end else if (wr_en && sel_afc) begin
      auto_flow_en <= pwdata[`AFC_BIT];
    end
  end

  // with flow control and fifos on, request-to-send falls back only once the fifo drains below trigger
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      rts_n <= 1'b1;
    end else begin
      rts_n <= auto_flow_en & fifos_enabled_indication & rx_lv.hit;
    end
  end

  // ==========================================================
  // pending interrupt identification
  // busy detect sits last; it only shows when nothing else waits
  always_comb begin
    pending_interrupt_code = ID_NONE_E;
    if (line_status_irq) begin
      pending_interrupt_code = ID_LINE_E;
    end else if (rx_data_irq_en && (fifos_enabled_indication ?
                 rx_lv.hit : (rx_fifo_count != 5'h00))) begin
      pending_interrupt_code = ID_RX_DATA_E;
    end else if (char_timeout_irq) begin
      pending_interrupt_code = ID_TIMEOUT_E;
    end else if (holding_empty_interrupt) begin
      pending_interrupt_code = ID_HOLDING_EMPTY_INTERRUPT_E;
    end else if (modem_status_irq) begin
      pending_interrupt_code = ID_MODEM_E;
    end else if (busy_detect_irq) begin
      pending_interrupt_code = ID_BUSY_E;
    end
  end

  // ==========================================================
  // dma request hold state for mode 1
  // holds keep mode 1 requests up until the rx fifo empties or the tx fifo fills
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      rx_req_hold <= 1'b0;
      tx_req_hold <= 1'b0;
    end else begin
      if (rx_lv.hit) begin
        rx_req_hold <= 1'b1;
      end else if (rx_fifo_count == 5'h00) begin
        rx_req_hold <= 1'b0;
      end
      if (tx_lv.hit) begin
        tx_req_hold <= 1'b1;
      end else if (tx_fifo_count >= `FIFO_DEPTH) begin
        tx_req_hold <= 1'b0;
      end
    end
  end

  // mode 0, or mode 1 with fifos off, follows single characters; mode 1 with fifos on the programmed levels
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      dma_rx_req_n <= 1'b1;
      dma_tx_req_n <= 1'b1;
    end else if (dma_signalling_mode && fifos_enabled_indication) begin
      dma_rx_req_n <= ~rx_req_hold;
      dma_tx_req_n <= ~tx_req_hold;
    end else begin
      dma_rx_req_n <= (rx_fifo_count == 5'h00);
      dma_tx_req_n <= (tx_fifo_count != 5'h00);
    end
  end

  // ==========================================================
  // interrupt events: rx trigger, tx threshold, new pending cause
  // rising edges only, so a level that stays up sets its bit once
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      rx_hit_d <= 1'b0;
      tx_hit_d <= 1'b0;
      pend_d   <= 1'b0;
    end else begin
      rx_hit_d <= rx_lv.hit;
      tx_hit_d <= tx_lv.hit;
      pend_d   <= (pending_interrupt_code != ID_NONE_E);
    end
  end

  assign irq_event = {(pending_interrupt_code != ID_NONE_E) & ~pend_d,
                      tx_lv.hit & ~tx_hit_d,
                      rx_lv.hit & ~rx_hit_d};

  // set wins over a write-one clear in the same cycle
  always_comb begin
    next_irq_status = irq_status;
    if (wr_en && sel_sts) begin
      next_irq_status = irq_status & ~pwdata[2:0];
    end
    next_irq_status = next_irq_status | irq_event;
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      irq_status <= `IRQ_RESET;
    end else begin
      irq_status <= next_irq_status;
    end
  end

  // ==========================================================
  // interrupt mask and output
  // next mask used so irq never lags a mask write by a cycle
  always_comb begin
    next_irq_mask = irq_mask;
    if (wr_en && sel_msk) begin
      next_irq_mask = pwdata[2:0];
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      irq_mask <= `IRQ_RESET;
    end else begin
      irq_mask <= next_irq_mask;
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      irq <= 1'b0;
    end else begin
      irq <= |(next_irq_status & next_irq_mask);
    end
  end

  // ==========================================================
  // read data
  assign fifo_state_rx_level_field = {
    fifos_enabled_indication ? `FIFOS_ENABLED_INDICATION_ON : `FIFOS_ENABLED_INDICATION_OFF,
    2'h0,
    pending_interrupt_code};

  // read mux; captured in the setup cycle so prdata comes from a flop
  always_comb begin
    next_prdata = 32'h0000_0000;
    case (1'b1)
      sel_fcr: next_prdata = {24'h00_0000, fifo_state_rx_level_field};
      sel_sts: next_prdata = {29'h0, irq_status};
      sel_msk: next_prdata = {29'h0, irq_mask};
      sel_afc: next_prdata = {31'h0, auto_flow_en};
      default: next_prdata = 32'h0000_0000;
    endcase
  end

  // ==========================================================
  // read data register
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      prdata <= 32'h0000_0000;
    end else if (psel && !penable && !pwrite) begin
      prdata <= next_prdata;
    end else if (!(psel && penable)) begin
      prdata <= 32'h0000_0000;
    end
  end
endmodule : uart_fifo_ctrl_int_ident

// File: tb/uart_iir_checker.sv
// concurrent checks on the fifo control and identification ports
`timescale 1ns/1ps
`include "uart_iir_defs.svh"
module uart_iir_checker (
  // clock, reset and apb
  input wire logic        mclk,
  input wire logic        rst_n,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  // fifo levels and causes
  input wire logic [4:0]  rx_fifo_count,
  input wire logic [4:0]  tx_fifo_count,
  input wire logic        line_status_irq,
  // watched outputs
  input wire logic        fifos_enabled_indication,
  input wire logic        transmit_fifo_clear,
  input wire logic        rts_n,
  input wire logic        dma_rx_req_n,
  input wire logic        dma_tx_req_n
);
  // ==========================================================
  // helpers
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rst_n);
  logic rd_id;
  logic wr_id;
  assign rd_id = psel && penable && !pwrite && paddr == `IIR_FCR_ADDR;
  assign wr_id = psel && penable && pwrite && paddr == `IIR_FCR_ADDR;
  // ==========================================================
  // properties
  a_fifos_enabled_indication_read: assert property (
    rd_id |-> prdata[7:6] == {2{fifos_enabled_indication}})
    else $error("fifo enable indication wrong");
  a_tet_reserved: assert property (rd_id |-> prdata[5:4] == 2'h0)
    else $error("reserved bits not zero");
  a_line_first: assert property (
    rd_id && line_status_irq && $past(line_status_irq) |->
    prdata[3:0] == 4'h6)
    else $error("line status not ranked first");
  a_xclr_pulse: assert property (wr_id && pwdata[2] |=> transmit_fifo_clear)
    else $error("tx clear missing");
  a_xclr_self: assert property (
    transmit_fifo_clear && !wr_id |=> !transmit_fifo_clear)
    else $error("tx clear stuck");
  a_rx_dma_off: assert property (
    rst_n && !fifos_enabled_indication |=>
    dma_rx_req_n == ($past(rx_fifo_count) == 5'h0))
    else $error("rx dma wrong with fifos off");
  a_tx_dma_off: assert property (
    rst_n && !fifos_enabled_indication |=>
    dma_tx_req_n == ($past(tx_fifo_count) != 5'h0))
    else $error("tx dma wrong with fifos off");
  a_rts_empty: assert property (
    rst_n && rx_fifo_count == 5'h0 |=> !rts_n)
    else $error("rts dropped on empty fifo");
endmodule : uart_iir_checker
bind uart_fifo_ctrl_int_ident uart_iir_checker uart_iir_checker_inst (.*);

// File: tb/serial_sender.sv
// remote serial sender that honours request-to-send
`timescale 1ns/1ps
module serial_sender (
  // clock and flow
  input  wire logic       mclk,
  input  wire logic       rst_n,
  input  wire logic       rts_n,
  // wanted and actual receive fill level
  input  wire logic [4:0] want,
  output logic      [4:0] level
);
  // ==========================================================
  // one character every third cycle, so a late rts_n never overruns
  logic [1:0] gap;
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      gap   <= 2'h0;
      level <= 5'h00;
    end else begin
      gap <= (gap == 2'h2) ? 2'h0 : gap + 2'h1;
      if (level > want)
        level <= level - 5'h01;
      else if (level < want && !rts_n && gap == 2'h0)
        level <= level + 5'h01;
    end
  end
endmodule : serial_sender

// File: tb/tb.sv
// self-checking bench for the fifo control and identification block
`timescale 1ns/1ps
`include "uart_iir_defs.svh"
module tb;
  // ==========================================================
  // signals
  logic        mclk, rst_n, psel, penable, pwrite, pready, pslverr, se;
  logic [31:0] paddr, pwdata, prdata, r;
  logic [4:0]  want, rx_fifo_count, tx_fifo_count;
  logic        line_status_irq, rx_data_irq_en, char_timeout_irq;
  logic        holding_empty_interrupt, modem_status_irq, busy_detect_irq;
  logic        fifos_enabled_indication, transmit_fifo_clear, irq;
  logic        receive_fifo_clear, rts_n, dma_rx_req_n, dma_tx_req_n;
  logic [5:0]  cz;
  int          err_total, n_tests, c, i;
  int          xclr_seen, rclr_seen;
  localparam logic [31:0] IIR = `IIR_FCR_ADDR;
  localparam logic [31:0] STA = `IRQ_STATUS_ADDR;
  localparam logic [31:0] MSK = `IRQ_MASK_ADDR;
  localparam logic [31:0] FLW = `FLOW_CTRL_ADDR;
  uart_fifo_ctrl_int_ident uart_fifo_ctrl_int_ident_inst (.*);
  serial_sender serial_sender_inst (.mclk, .rst_n, .rts_n, .want,
                                    .level(rx_fifo_count));
  // ==========================================================
  // expectations and tasks
  function automatic logic [4:0] rx_lvl(input int k);
    return k == 0 ? `RX_LVL_ONE : k == 1 ? `RX_LVL_QUARTER :
           k == 2 ? `RX_LVL_HALF : `RX_LVL_TWO_LESS;
  endfunction : rx_lvl
  function automatic logic [4:0] tx_thr(input int k);
    return k == 0 ? 5'h00 : 5'(1 << k);
  endfunction : tx_thr
  function automatic logic [3:0] id_exp(input logic [5:0] v);
    if (v[5]) return `ID_LINE;
    if (v[4]) return `ID_RX_DATA;
    if (v[3]) return `ID_TIMEOUT;
    if (v[2]) return `ID_HOLDING_EMPTY_INTERRUPT;
    if (v[1]) return `ID_MODEM;
    if (v[0]) return `ID_BUSY;
    return `ID_NONE;
  endfunction : id_exp
  task automatic chk(input string s, input logic [31:0] e, g);
    n_tests++;
    if (g !== e) begin
      $display("CHECK FAILED %s expected %h seen %h", s, e, g);
      err_total++;
    end
  endtask : chk
  // caller sits just after a rising edge
  task automatic apb(input logic w, input logic [31:0] a, d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    do @(posedge mclk); while (pready !== 1'b1);
    r = prdata;
    se = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge mclk);
  endtask : apb
  task automatic fill(input logic [4:0] v);
    want <= v;
    for (i = 0; i < 100 && rx_fifo_count !== v; i++) @(posedge mclk);
    repeat (3) @(posedge mclk);
  endtask : fill
  task automatic tx_step(input logic [4:0] v, input logic e);
    tx_fifo_count <= v;
    repeat (3) @(posedge mclk);
    chk("tx dma request", e, dma_tx_req_n);
  endtask : tx_step
  task automatic close_out();
    $display("checks %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : close_out
  // ==========================================================
  // clock, watchdog, tests
  initial begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end
  // clear pulses counted mid-cycle, where they are settled
  always @(negedge mclk) begin
    if (transmit_fifo_clear === 1'b1) xclr_seen++;
    if (receive_fifo_clear === 1'b1) rclr_seen++;
  end
  initial begin
    repeat (20000) @(posedge mclk);
    err_total++;
    close_out();
  end
  initial begin
    {rst_n, psel, penable, pwrite, paddr, pwdata, want} = '0;
    {tx_fifo_count, line_status_irq, rx_data_irq_en, char_timeout_irq} = '0;
    {holding_empty_interrupt, modem_status_irq, busy_detect_irq} = '0;
    c = $urandom(32'hA78D);
    repeat (6) @(posedge mclk);
    rst_n <= 1'b1;
    @(posedge mclk);
    apb(0, IIR, 0);
    chk("ident at reset", 32'h01, r);
    apb(0, MSK, 0);
    chk("mask at reset", 0, r);
    apb(0, IIR + 32'h400, 0);
    chk("unmapped error", 1, se);
    $display("test reset done");
    apb(1, FLW, 1);
    for (c = 0; c < 4; c++) begin
      apb(1, IIR, {c[1:0], 6'h01});
      want <= 5'h10;
      for (i = 0; i < 200 && rts_n !== 1'b1; i++) @(posedge mclk);
      repeat (4) @(posedge mclk);
      chk("rts stop level", rx_lvl(c), rx_fifo_count);
      apb(0, IIR, 0);
      chk("fifos on read", 32'hC1, r);
      chk("fifo enable out", 1, fifos_enabled_indication);
      fill(0);
      chk("rts after drain", 0, rts_n);
    end
    apb(1, FLW, 0);
    $display("test flow control done");
    for (c = 0; c < 4; c++) begin
      apb(1, IIR, {c[1:0], 6'h09});
      fill(rx_lvl(c) - 5'h01);
      chk("rx dma below", 1, dma_rx_req_n);
      fill(rx_lvl(c));
      chk("rx dma at level", 0, dma_rx_req_n);
      fill(5'h01);
      chk("rx dma held", 0, dma_rx_req_n);
      fill(0);
      chk("rx dma empty", 1, dma_rx_req_n);
      apb(1, IIR, {2'h0, c[1:0], 4'h9});
      tx_step(5'h10, 1);
      tx_step(tx_thr(c), 0);
      tx_step(tx_thr(c) + 5'h01, 0);
      tx_step(5'h10, 1);
    end
    // mode 0 ignores the levels
    apb(1, IIR, 32'h01);
    tx_step(5'h01, 1);
    tx_step(5'h00, 0);
    fill(1);
    chk("rx dma mode 0", 0, dma_rx_req_n);
    $display("test dma done");
    for (c = 0; c < 24; c++) begin
      cz = c == 0 ? 6'h3F : c == 1 ? 6'h17 : 6'($urandom);
      cz[3] = cz[3] & ~cz[4];
      {line_status_irq, rx_data_irq_en, char_timeout_irq} <= cz[5:3];
      {holding_empty_interrupt, modem_status_irq, busy_detect_irq} <= cz[2:0];
      repeat (2) @(posedge mclk);
      apb(0, IIR, 0);
      chk("pending code", {24'h0, 4'hC, id_exp(cz)}, r);
    end
    {line_status_irq, rx_data_irq_en, char_timeout_irq} <= 3'h0;
    {holding_empty_interrupt, modem_status_irq, busy_detect_irq} <= 3'h0;
    $display("test ident done");
    c = xclr_seen;
    i = rclr_seen;
    apb(1, IIR, 32'h05);
    @(posedge mclk);
    chk("tx clear pulse", 1, xclr_seen - c);
    chk("tx clear ends", 0, transmit_fifo_clear);
    chk("no rx clear", 0, rclr_seen - i);
    apb(1, IIR, 32'h03);
    chk("rx clear pulse", 1, rclr_seen - i);
    chk("tx clear once", 1, xclr_seen - c);
    $display("test tx clear done");
    fill(0);
    apb(1, STA, 32'hFF);
    apb(1, MSK, 1);
    fill(1);
    chk("irq raised", 1, irq);
    apb(1, MSK, 0);
    repeat (2) @(posedge mclk);
    chk("irq masked", 0, irq);
    apb(1, MSK, 1);
    apb(1, STA, 1);
    apb(0, STA, 0);
    chk("status cleared", 0, r & 32'h1);
    chk("irq cleared", 0, irq);
    $display("test interrupt done");
    close_out();
  end
endmodule : tb
